// ==== src/sar_adc_sequencer.sv ====
// Successive-approximation converter sequencer with its register file
//
// Local design decisions: the register addresses and the strobed register port.
`include "sar_adc_consts.svh"

// Summary of operation
// - Pin enable pair selects edge per pin
// - Sample six of sixteen steps, then hold until done
// - Conversion starts with SAR top bit set
// - Keep bit if input at tap, next bit
// - After bit 0 store result, pulse done
// - Repeat conversions while enable bit set
// - Mode or channel write cuts short the running conversion
// - Reset clears the result register
// - Result is rounded ratio times 1024
// - Hardware start waits for trigger edge
// - Hardware start: one conversion per edge seen while waiting
// - Hardware start: channel write awaits new edge
// - Mode write with enable clear halts at once
// - Software start converts back to back
// - Software start: channel write restarts at once
// - Time code picks 144/576/480/384 clocks
// - Channel codes 0-9, upper bits read zero
// - Edge field: none, fall, rise, both
// - Mode or channel write beats end of conversion
module sar_adc_sequencer (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Trigger and external interrupt pins
   input wire logic external_trigger_in,
   input wire logic [5:0] ext_interrupt_pin,
   output logic [5:0] ext_int_req,
   // Analog front end
   input wire logic comp_ge,
   output logic [9:0] tap_code,
   output logic [3:0] analog_chan,
   output logic sampling,
   output logic booster_on,
   // Completion
   output logic conversion_done_irq
);
   import sar_adc_pkg::*;

   // ****************************************
   // Declarations
   // ****************************************
   logic [7:0] mode_ff, rdata_ff;
   logic [3:0] chan_ff, phase_ff, bit_idx_ff;
   logic [5:0] rise_en_ff, fall_en_ff, step_cnt_ff;
   logic [9:0] result_ff, sar_ff, age_ff;
   logic [2:0] fr_code;
   seq_state_t state_ff, nxt_state;
   logic sampling_ff, irq_ff, trig_pulse, mode_wr, chan_wr, any_wr;
   logic hw_mode, step_tick, last_bit, conv_done, begin_conv, busy_next;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   // Total clocks of one conversion; prohibited codes fall back to 144
   function automatic logic [9:0] conv_clocks(input logic [2:0] fr);
      case (fr)
         `FR_576: conv_clocks = `CLK_576;
         `FR_480: conv_clocks = `CLK_480;
         `FR_384: conv_clocks = `CLK_384;
         default: conv_clocks = `CLK_144;
      endcase
   endfunction

   // ****************************************
   // Register writes
   // ****************************************
   assign mode_wr = reg_wr && (reg_addr == `OFS_MODE);
   assign chan_wr = reg_wr && (reg_addr == `OFS_CHAN);
   assign any_wr = mode_wr || chan_wr;
   assign hw_mode = mode_ff[`MODE_HWSTART];
   assign fr_code = mode_ff[`MODE_FR_HI:`MODE_FR_LO];

   // Mode register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mode_ff <= `MODE_RESET;
      end else if (mode_wr) begin
         mode_ff <= reg_wdata;
      end
   end

   // Channel register keeps only the four channel bits
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         chan_ff <= `CHAN_RESET;
      end else if (chan_wr) begin
         chan_ff <= reg_wdata[3:0];
      end
   end

   // External interrupt edge enables
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rise_en_ff <= `EDGE_RESET;
         fall_en_ff <= `EDGE_RESET;
      end else if (reg_wr && reg_addr == `OFS_RISE_EN) begin
         rise_en_ff <= reg_wdata[5:0];
      end else if (reg_wr && reg_addr == `OFS_FALL_EN) begin
         fall_en_ff <= reg_wdata[5:0];
      end
   end

   // Read data stand only in the cycle after the read strobe
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= `RDATA_IDLE;
      end else if (reg_rd) begin
         case (reg_addr)
            `OFS_MODE: rdata_ff <= mode_ff;
            `OFS_CHAN: rdata_ff <= {4'h0, chan_ff};
            `OFS_RISE_EN: rdata_ff <= {2'h0, rise_en_ff};
            `OFS_FALL_EN: rdata_ff <= {2'h0, fall_en_ff};
            `OFS_RES_LO: rdata_ff <= result_ff[7:0];
            `OFS_RES_HI: rdata_ff <= {6'h00, result_ff[9:8]};
            default: rdata_ff <= `RDATA_IDLE;
         endcase
      end else begin
         rdata_ff <= `RDATA_IDLE;
      end
   end

   // ****************************************
   // Edge detection
   // ****************************************
   // One detector per external interrupt pin
   for (genvar i = 0; i < 6; i++) begin : g_pin
      edge_pick u_pin (
         .mclk(mclk),
         .rst_n(rst_n),
         .pin(ext_interrupt_pin[i]),
         .rise_en(rise_en_ff[i]),
         .fall_en(fall_en_ff[i]),
         .pulse(ext_int_req[i])
      );
   end

   // Trigger edge chosen by the mode edge field
   edge_pick u_trig (
      .mclk(mclk),
      .rst_n(rst_n),
      .pin(external_trigger_in),
      .rise_en(mode_ff[`MODE_EDGE_RISE]),
      .fall_en(mode_ff[`MODE_EDGE_FALL]),
      .pulse(trig_pulse)
   );

   // ****************************************
   // Sequencer
   // ****************************************
   // Last clock of one of the sixteen equal steps
   assign step_tick = step_cnt_ff ==
                      6'((conv_clocks(fr_code) >> `STEP_SHIFT) - 10'h001);
   assign last_bit = state_ff == st_convert && step_tick && bit_idx_ff == 4'h0;
   assign conv_done = last_bit && !any_wr;
   assign busy_next = nxt_state == st_sample || nxt_state == st_convert;

   // Next state; mode and channel writes take priority over the sequence
   always_comb begin
      nxt_state = state_ff;
      begin_conv = 1'b0;
      if (mode_wr) begin
         if (!reg_wdata[`MODE_ENABLE]) begin
            nxt_state = st_idle;
         end else if (reg_wdata[`MODE_HWSTART]) begin
            nxt_state = st_wait_trig;
         end else begin
            nxt_state = st_sample;
            begin_conv = 1'b1;
         end
      end else if (chan_wr && state_ff != st_idle) begin
         if (hw_mode) begin
            nxt_state = st_wait_trig;
         end else begin
            nxt_state = st_sample;
            begin_conv = 1'b1;
         end
      end else begin
         unique case (state_ff)
            st_idle: nxt_state = st_idle;
            st_wait_trig: if (trig_pulse) begin
               nxt_state = st_sample;
               begin_conv = 1'b1;
            end
            st_sample: if (step_tick && phase_ff == `SAMPLE_LAST) begin
               nxt_state = st_convert;
            end
            // Edges here are not seen and not queued
            st_convert: if (last_bit) begin
               if (hw_mode) begin
                  nxt_state = st_wait_trig;
               end else begin
                  nxt_state = st_sample;
                  begin_conv = 1'b1;
               end
            end
         endcase
      end
   end

   // State register; sample switch closed only while sampling
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= st_idle;
         sampling_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         sampling_ff <= nxt_state == st_sample;
      end
   end

   // Step and phase counters spread the conversion over its clocks
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         step_cnt_ff <= 6'h00;
         phase_ff <= 4'h0;
      end else if (begin_conv || !busy_next) begin
         step_cnt_ff <= 6'h00;
         phase_ff <= 4'h0;
      end else if (step_tick) begin
         step_cnt_ff <= 6'h00;
         phase_ff <= phase_ff + 4'h1;
      end else begin
         step_cnt_ff <= step_cnt_ff + 6'h01;
      end
   end

   // Approximation register; tap thresholds sit half a step low
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sar_ff <= `RESULT_RESET;
         bit_idx_ff <= `MSB_IDX;
      end else if (state_ff == st_sample && nxt_state == st_convert) begin
         sar_ff <= `SAR_MSB_SET;
         bit_idx_ff <= `MSB_IDX;
      end else if (state_ff == st_convert && step_tick && !any_wr) begin
         sar_ff[bit_idx_ff] <= comp_ge;
         if (bit_idx_ff != 4'h0) begin
            sar_ff[bit_idx_ff - 4'h1] <= 1'b1;
            bit_idx_ff <= bit_idx_ff - 4'h1;
         end
      end
   end

   // Result and done pulse in the same step
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         result_ff <= `RESULT_RESET;
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= conv_done;
         if (conv_done) begin
            result_ff <= {sar_ff[9:1], comp_ge};
         end
      end
   end

   // Clocks spent in the running conversion, read by checks only
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         age_ff <= 10'h000;
      end else if (begin_conv) begin
         age_ff <= 10'h000;
      end else if (state_ff == st_sample || state_ff == st_convert) begin
         age_ff <= age_ff + 10'h001;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign reg_rdata = rdata_ff;
   assign tap_code = sar_ff;
   assign analog_chan = chan_ff;
   assign sampling = sampling_ff;
   assign booster_on = mode_ff[`MODE_BOOST];
   assign conversion_done_irq = irq_ff;

   // ****************************************
   // Checks
   // ****************************************
   sequence seq_sample_end;
      state_ff == st_sample && step_tick && phase_ff == `SAMPLE_LAST &&
      !any_wr;
   endsequence
   sequence seq_hold_start;
      state_ff == st_convert && !sampling_ff && sar_ff == `SAR_MSB_SET;
   endsequence

   chk_msb_first: assert property (seq_sample_end |=> seq_hold_start)
      else $error("conversion did not start with top bit in hold");
   chk_hold_convert: assert property (
      state_ff == st_convert |-> !sampling_ff)
      else $error("sample switch closed during bit decisions");
   chk_next_trial: assert property (
      state_ff == st_convert && step_tick && !any_wr &&
      bit_idx_ff != 4'h0 |=>
      sar_ff[$past(bit_idx_ff) - 4'h1] && bit_idx_ff == $past(bit_idx_ff) - 4'h1)
      else $error("next trial bit not set");
   chk_result_store: assert property (
      conversion_done_irq |-> result_ff == sar_ff && $past(last_bit))
      else $error("done pulse without matching result");
   // Age is reset at the start edge, so the last edge sees one less
   chk_conv_time: assert property (
      conv_done |-> age_ff == conv_clocks(fr_code) - 10'h001)
      else $error("conversion length differs from selected time");
   chk_write_wins: assert property (
      any_wr |=> !conversion_done_irq)
      else $error("done pulse despite coinciding register write");
   chk_stop_now: assert property (
      mode_wr && !reg_wdata[`MODE_ENABLE] |=>
      state_ff == st_idle && !sampling_ff)
      else $error("conversion not halted by enable clear");
   chk_hw_rewait: assert property (
      conv_done && hw_mode |=> state_ff == st_wait_trig ##1 !sampling_ff)
      else $error("hardware start continued without new edge");
   chk_sw_repeat: assert property (
      conv_done && !hw_mode |=> state_ff == st_sample && sampling_ff)
      else $error("software start did not repeat");
   chk_trig_start: assert property (
      state_ff == st_wait_trig && trig_pulse && !any_wr |=> sampling_ff)
      else $error("trigger edge did not start conversion");
   chk_chan_sw: assert property (
      chan_wr && !hw_mode && state_ff != st_idle && !mode_wr |=>
      sampling_ff && age_ff == 10'h000)
      else $error("channel write did not restart conversion");
endmodule

// ==== src/sar_adc_consts.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH

// ****************************************
// Register offsets on the register port
// ****************************************
`define OFS_RISE_EN 8'h48
`define OFS_FALL_EN 8'h49
`define OFS_MODE 8'h80
`define OFS_CHAN 8'h81
`define OFS_RES_LO 8'h82
`define OFS_RES_HI 8'h83

// ****************************************
// Reset values
// ****************************************
`define MODE_RESET 8'h00
`define CHAN_RESET 4'h0
`define EDGE_RESET 6'h00
`define RESULT_RESET 10'h000
`define RDATA_IDLE 8'h00

// ****************************************
// Mode register fields
// ****************************************
`define MODE_ENABLE 7
`define MODE_HWSTART 6
`define MODE_FR_HI 5
`define MODE_FR_LO 3
`define MODE_EDGE_RISE 2
`define MODE_EDGE_FALL 1
`define MODE_BOOST 0

// ****************************************
// Conversion time codes and clock counts
// ****************************************
`define FR_576 3'h4
`define FR_480 3'h5
`define FR_384 3'h6
`define CLK_144 10'h090
`define CLK_576 10'h240
`define CLK_480 10'h1e0
`define CLK_384 10'h180
// Sixteen equal steps: six for sampling, ten for bit decisions
`define STEP_SHIFT 4
`define SAMPLE_LAST 4'h5
`define SAR_MSB_SET 10'h200
`define MSB_IDX 4'h9

`endif

// ==== src/sar_adc_pkg.sv ====
// Types shared by the converter sequencer
package sar_adc_pkg;
   typedef enum logic [1:0] {
      st_idle,
      st_wait_trig,
      st_sample,
      st_convert
   } seq_state_t;
endpackage

// ==== src/edge_pick.sv ====
// Selectable rising/falling edge detector for one pin
`include "sar_adc_consts.svh"

module edge_pick (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Pin and edge selection
   input wire logic pin,
   input wire logic rise_en,
   input wire logic fall_en,
   // Detected edge
   output logic pulse
);
   logic prev_ff;
   logic armed_ff;
   logic pulse_ff;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   // Previous pin level; armed one clock after reset so no false edge
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prev_ff <= 1'b0;
         armed_ff <= 1'b0;
      end else begin
         prev_ff <= pin;
         armed_ff <= 1'b1;
      end
   end

   // Edge pulse: both enables clear means nothing is detected
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pulse_ff <= 1'b0;
      end else begin
         pulse_ff <= armed_ff && ((rise_en && pin && !prev_ff) ||
                                  (fall_en && !pin && prev_ff));
      end
   end

   assign pulse = pulse_ff;

   chk_edge_rise_seen: assert property (
      armed_ff && rise_en && pin && !prev_ff |=> pulse)
      else $error("selected rising edge not reported");

   chk_edge_fall_seen: assert property (
      armed_ff && fall_en && !pin && prev_ff |=> pulse)
      else $error("selected falling edge not reported");

   chk_edge_disabled: assert property (
      !rise_en && !fall_en |=> !pulse)
      else $error("edge reported while detection disabled");
endmodule

// ==== test/analog_front_model.sv ====
// Behavioural sample-and-hold and comparator facing the sequencer
module analog_front_model (
   // Clock
   input wire logic mclk,
   // Sequencer side
   input wire logic [9:0] tap_code,
   input wire logic [3:0] analog_chan,
   input wire logic sampling,
   // Input levels in LSB units, one per channel
   input wire logic [9:0] level [10],
   // Comparator result
   output logic comp_ge
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] held_ff = 10'h000;

   // Track the channel while sampling, keep it while held
   always_ff @(posedge mclk) begin
      if (sampling) begin
         held_ff <= (analog_chan < 4'ha) ? level[analog_chan] : 10'h000;
      end
   end

   // Half-LSB rounding lives in the tap offset, so compare codes
   assign comp_ge = (held_ff >= tap_code);
endmodule

// ==== test/sar_adc_sequencer_tb.sv ====
// Self-checking bench for the converter sequencer
`include "sar_adc_consts.svh"

module sar_adc_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, rst_n, reg_wr, reg_rd, external_trigger_in, comp_ge;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [5:0] ext_interrupt_pin, ext_int_req;
   logic [9:0] tap_code;
   logic [3:0] analog_chan;
   logic sampling, booster_on, conversion_done_irq;
   logic [9:0] level [10];
   int err_total = 0;
   int total_checks = 0;
   int done_cnt = 0;
   int cycles = 0;
   int clk_n [4] = '{144, 576, 480, 384};
   logic [2:0] code_n [4] = '{3'h0, `FR_576, `FR_480, `FR_384};

   sar_adc_sequencer dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .external_trigger_in(external_trigger_in),
      .ext_interrupt_pin(ext_interrupt_pin), .ext_int_req(ext_int_req),
      .comp_ge(comp_ge), .tap_code(tap_code), .analog_chan(analog_chan),
      .sampling(sampling), .booster_on(booster_on),
      .conversion_done_irq(conversion_done_irq));

   analog_front_model afe (.mclk(mclk), .tap_code(tap_code),
      .analog_chan(analog_chan), .sampling(sampling), .level(level),
      .comp_ge(comp_ge));

   // Clock
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // Done pulse counter and hang guard
   always @(posedge mclk) begin
      cycles++;
      if (conversion_done_irq === 1'b1) begin
         done_cnt++;
      end
      if (cycles == 30000) begin
         err_total++;
         summarize();
      end
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic get_res(output logic [9:0] r);
      logic [7:0] lo, hi;
      rd(`OFS_RES_LO, lo);
      rd(`OFS_RES_HI, hi);
      r = {hi[1:0], lo};
   endtask

   // Cycles from now until the done pulse is visible
   task automatic wait_done(output int n);
      n = 0;
      do begin
         @(posedge mclk);
         #1 n++;
      end while (conversion_done_irq !== 1'b1 && n < 700);
   endtask

   task automatic quiet(input int len, input int exp);
      int c0;
      c0 = done_cnt;
      repeat (len) @(posedge mclk);
      check("done count", 16'(done_cnt - c0), 16'(exp));
   endtask

   task automatic trig(input logic v, input int exp, input bit glitch);
      int c0;
      c0 = done_cnt;
      @(posedge mclk);
      external_trigger_in <= v;
      if (glitch) begin
         repeat (40) @(posedge mclk);
         external_trigger_in <= ~v;
         repeat (3) @(posedge mclk);
         external_trigger_in <= v;
      end
      repeat (300) @(posedge mclk);
      check("trig done", 16'(done_cnt - c0), 16'(exp));
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_regs();
      logic [7:0] d;
      logic [7:0] ofs [7] = '{`OFS_RISE_EN, `OFS_FALL_EN, `OFS_MODE,
                              `OFS_CHAN, `OFS_RES_LO, `OFS_RES_HI, 8'h50};
      check("tap reset", tap_code, 10'h000);
      for (int i = 0; i < 7; i++) begin
         rd(ofs[i], d);
         check("reset read", d, 8'h00);
      end
      wr(8'h50, 8'hff);
      rd(8'h50, d);
      check("unmapped", d, 8'h00);
      wr(`OFS_CHAN, 8'hff);
      rd(`OFS_CHAN, d);
      check("chan bits", d, 8'h0f);
      wr(`OFS_RISE_EN, 8'hff);
      rd(`OFS_RISE_EN, d);
      check("rise bits", d, 8'h3f);
      wr(`OFS_RISE_EN, 8'h00);
      wr(`OFS_MODE, 8'h01);
      #1 check("booster", booster_on, 1'b1);
      $display("t_regs finished");
   endtask

   task automatic t_edges();
      logic [5:0] acc;
      wr(`OFS_RISE_EN, 8'h05);
      wr(`OFS_FALL_EN, 8'h06);
      for (int k = 0; k < 2; k++) begin
         acc = 6'h00;
         @(posedge mclk);
         ext_interrupt_pin <= k ? 6'h00 : 6'h0f;
         repeat (4) begin
            @(posedge mclk);
            #1 acc = acc | ext_int_req;
         end
         check("edge req", acc, k ? 6'h06 : 6'h05);
      end
      $display("t_edges finished");
   endtask

   task automatic t_times();
      int n;
      logic [9:0] r;
      for (int i = 0; i < 4; i++) begin
         wr(`OFS_CHAN, 8'(i));
         wr(`OFS_MODE, {2'b10, code_n[i], 3'b001});
         if (i == 0) begin
            // Sampling stands 54 cycles from the write edge
            repeat (53) @(posedge mclk);
            #1 check("sampling", sampling, 1'b1);
            @(posedge mclk);
            #1 check("hold", sampling, 1'b0);
            check("top bit", tap_code, 10'h200);
         end
         wait_done(n);
         check("span", 16'(n), 16'(clk_n[i] - (i == 0 ? 54 : 0)));
         wait_done(n);
         check("next span", 16'(n), 16'(clk_n[i]));
         get_res(r);
         check("result", r, level[i]);
         wr(`OFS_MODE, 8'h01);
         @(posedge mclk);
         #1 check("halted", sampling, 1'b0);
         quiet(clk_n[i] + 20, 0);
      end
      $display("t_times finished");
   endtask

   task automatic t_restart();
      int n;
      logic [9:0] r;
      wr(`OFS_CHAN, 8'h01);
      wr(`OFS_MODE, 8'h81);
      repeat (60) @(posedge mclk);
      wr(`OFS_CHAN, 8'h03);
      wait_done(n);
      check("chan restart", 16'(n), 16'd144);
      check("chan out", analog_chan, 4'h3);
      get_res(r);
      check("new chan res", r, level[3]);
      repeat (30) @(posedge mclk);
      wr(`OFS_MODE, 8'h81);
      wait_done(n);
      check("mode restart", 16'(n), 16'd144);
      wr(`OFS_MODE, 8'h01);
      $display("t_restart finished");
   endtask

   task automatic t_hw();
      for (int e = 0; e < 4; e++) begin
         wr(`OFS_MODE, {5'b11000, 2'(e), 1'b1});
         repeat (20) @(posedge mclk);
         #1 check("standby", sampling, 1'b0);
         trig(1'b1, e / 2, e == 3);
         trig(1'b0, e % 2, 1'b0);
      end
      wr(`OFS_MODE, 8'h01);
      $display("t_hw finished");
   endtask

   task automatic t_hw_chan();
      logic [9:0] r;
      wr(`OFS_CHAN, 8'h02);
      wr(`OFS_MODE, 8'hc7);
      @(posedge mclk);
      external_trigger_in <= 1'b1;
      repeat (40) @(posedge mclk);
      wr(`OFS_CHAN, 8'h04);
      quiet(300, 0);
      #1 check("waiting", sampling, 1'b0);
      wr(`OFS_CHAN, 8'h05);
      trig(1'b0, 1, 1'b0);
      get_res(r);
      check("hw result", r, level[5]);
      wr(`OFS_MODE, 8'h01);
      $display("t_hw_chan finished");
   endtask

   task automatic t_clash();
      logic [9:0] prev, r;
      int c0;
      get_res(prev);
      wr(`OFS_CHAN, 8'h06);
      wr(`OFS_MODE, 8'h81);
      c0 = done_cnt;
      // Channel write taken on the very edge of the last bit decision
      repeat (142) @(posedge mclk);
      wr(`OFS_CHAN, 8'h07);
      repeat (2) @(posedge mclk);
      check("clash irq", 16'(done_cnt - c0), 16'd0);
      get_res(r);
      check("clash res", r, prev);
      wr(`OFS_MODE, 8'h01);
      $display("t_clash finished");
   endtask

   // Main sequence
   initial begin
      rst_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      external_trigger_in = 1'b0;
      ext_interrupt_pin = 6'h00;
      level = '{10'h3a5, 10'h000, 10'h155, 10'h2aa, 10'h200,
                10'h1ff, 10'h001, 10'h123, 10'h321, 10'h0f0};
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      t_regs();
      t_edges();
      t_times();
      t_restart();
      t_hw();
      t_hw_chan();
      t_clash();
      summarize();
   end
endmodule
